// ===== core/cssrs_top.sv
// Clock source select registers, update strobes, divider and reset status
`timescale 1ns/1ps
// Function
// - A low-to-high change of oscillator direct strobe applies new direct selection; zero keeps it.
// - Reset cause register records which sources caused reset, one flag each.
// - Flags: power-on bit 0, pin 1, watchdog 2, brown-out 3, software 4.
// - Writing one clears a reset cause flag; writing zero leaves it.
// - Power-on reset clears all other reset cause flags.
// - Source still asserted when power-on reset ends gets its flag set.
// - PLL input selector is 2 bits, reset 0, four oscillator/clock sources.
// - New PLL input selection applies only after its strobe goes low to high.
// - Final main selector 2 bits reset 0: pre-PLL, PLL, codes 2/3 none.
// - Final selector switches only when its strobe bit 0 rises.
// - Pre-PLL main selector is 2 bits, reset 0, four sources.
// - Pre-PLL selector adopts new source only when its strobe bit 0 rises.
// - System clock is main clock divided by ratio; zero stops it.
// - Ratio field 8 bits, reset 0x01, N divides by N, 0 disables.
module cssrs_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources: pin, watchdog, brown-out, software
  input wire logic [3:0] reset_src,
  // Clock selections
  output logic osc_direct_sel,
  output logic [1:0] pll_src_sel,
  output logic [1:0] main_prepll_sel,
  output logic [1:0] main_final_sel,
  output logic main_clk_stopped,
  output logic sys_clk_en,
  // Interrupt
  output logic irq
);
  localparam int SW = cssrs_pkg::SEL_W;
  localparam int RW = cssrs_pkg::RATIO_W;
  localparam int IW = cssrs_pkg::IRQ_W;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic osc_direct_pend, next_osc_direct_pend;
  logic [3:0] strobe, next_strobe;
  logic [SW-1:0] pll_pend, next_pll_pend;
  logic [SW-1:0] final_pend, next_final_pend;
  logic [SW-1:0] prepll_pend, next_prepll_pend;
  logic [RW-1:0] ratio, next_ratio;
  logic [IW-1:0] irq_status, next_irq_status;
  logic [IW-1:0] irq_mask, next_irq_mask;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;
  logic [RW-1:0] div_cnt, next_div_cnt;
  logic next_sys_clk_en, next_main_clk_stopped;
  logic wr, access, rc_clear_we;
  logic [cssrs_pkg::RC_W-1:0] rc_flags;
  logic rc_event;
  logic [IW-1:0] events;

  cssrs_upd_if #(.W(1)) osc_if ();
  cssrs_upd_if #(.W(SW)) pll_if ();
  cssrs_upd_if #(.W(SW)) final_if ();
  cssrs_upd_if #(.W(SW)) prepll_if ();

  function automatic logic [31:0] sel_word(input logic [SW-1:0] v);
    sel_word = {30'h0, v};
  endfunction

  function automatic logic [31:0] bit_word(input logic v);
    bit_word = {31'h0, v};
  endfunction

  // ----------------------------------------
  // Register file and APB
  // ----------------------------------------
  always_comb
  begin
    access = psel && penable && !pready;
    wr = psel && penable && pready && pwrite;
    rc_clear_we = wr && paddr == cssrs_pkg::ADDR_RST_CAUSE;
    next_osc_direct_pend = osc_direct_pend;
    next_strobe = strobe;
    next_pll_pend = pll_pend;
    next_final_pend = final_pend;
    next_prepll_pend = prepll_pend;
    next_ratio = ratio;
    next_irq_mask = irq_mask;
    next_pready = access;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    events = {rc_event, prepll_if.done, final_if.done, pll_if.done, osc_if.done};
    next_irq_status = irq_status;
    if (access)
    begin
      next_prdata = 32'h0;
      case (paddr)
        cssrs_pkg::ADDR_OSC_FREQ_CTRL:
          next_prdata[cssrs_pkg::OSC_DIRECT_BIT] = osc_direct_pend;
        cssrs_pkg::ADDR_OSC_UPD: next_prdata = bit_word(strobe[0]);
        cssrs_pkg::ADDR_RST_CAUSE: next_prdata = {27'h0, rc_flags};
        cssrs_pkg::ADDR_PLL_SEL: next_prdata = sel_word(pll_pend);
        cssrs_pkg::ADDR_PLL_UPD: next_prdata = bit_word(strobe[1]);
        cssrs_pkg::ADDR_FINAL_SEL: next_prdata = sel_word(final_pend);
        cssrs_pkg::ADDR_FINAL_UPD: next_prdata = bit_word(strobe[2]);
        cssrs_pkg::ADDR_PREPLL_SEL: next_prdata = sel_word(prepll_pend);
        cssrs_pkg::ADDR_PREPLL_UPD: next_prdata = bit_word(strobe[3]);
        cssrs_pkg::ADDR_RATIO: next_prdata = {24'h0, ratio};
        cssrs_pkg::ADDR_IRQ_STATUS: next_prdata = {27'h0, irq_status};
        cssrs_pkg::ADDR_IRQ_MASK: next_prdata = {27'h0, irq_mask};
        default: next_pslverr = 1'b1;
      endcase
    end
    if (wr)
    begin
      case (paddr)
        cssrs_pkg::ADDR_OSC_FREQ_CTRL:
          next_osc_direct_pend = pwdata[cssrs_pkg::OSC_DIRECT_BIT];
        cssrs_pkg::ADDR_OSC_UPD:
          next_strobe[0] = pwdata[cssrs_pkg::UPDATE_STROBE_BIT];
        cssrs_pkg::ADDR_PLL_SEL: next_pll_pend = pwdata[SW-1:0];
        cssrs_pkg::ADDR_PLL_UPD:
          next_strobe[1] = pwdata[cssrs_pkg::UPDATE_STROBE_BIT];
        cssrs_pkg::ADDR_FINAL_SEL: next_final_pend = pwdata[SW-1:0];
        cssrs_pkg::ADDR_FINAL_UPD:
          next_strobe[2] = pwdata[cssrs_pkg::UPDATE_STROBE_BIT];
        cssrs_pkg::ADDR_PREPLL_SEL: next_prepll_pend = pwdata[SW-1:0];
        cssrs_pkg::ADDR_PREPLL_UPD:
          next_strobe[3] = pwdata[cssrs_pkg::UPDATE_STROBE_BIT];
        cssrs_pkg::ADDR_RATIO: next_ratio = pwdata[RW-1:0];
        cssrs_pkg::ADDR_IRQ_STATUS: next_irq_status = irq_status & ~pwdata[IW-1:0];
        cssrs_pkg::ADDR_IRQ_MASK: next_irq_mask = pwdata[IW-1:0];
        default:
        begin
        end
      endcase
    end
    next_irq_status = next_irq_status | events;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_direct_pend <= 1'b0;
      strobe <= 4'h0;
      pll_pend <= cssrs_pkg::SEL_RESET;
      final_pend <= cssrs_pkg::SEL_RESET;
      prepll_pend <= cssrs_pkg::SEL_RESET;
      ratio <= cssrs_pkg::RATIO_RESET;
      irq_status <= '0;
      irq_mask <= '0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      osc_direct_pend <= next_osc_direct_pend;
      strobe <= next_strobe;
      pll_pend <= next_pll_pend;
      final_pend <= next_final_pend;
      prepll_pend <= next_prepll_pend;
      ratio <= next_ratio;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  // ----------------------------------------
  // Source switches
  // ----------------------------------------
  assign osc_if.pending = osc_direct_pend;
  assign osc_if.strobe = strobe[0];
  assign pll_if.pending = pll_pend;
  assign pll_if.strobe = strobe[1];
  assign final_if.pending = final_pend;
  assign final_if.strobe = strobe[2];
  assign prepll_if.pending = prepll_pend;
  assign prepll_if.strobe = strobe[3];

  cssrs_src_switch #(.W(1), .RESET_SEL(1'b0)) u_osc_sw (
    .pclk(pclk), .presetn(presetn), .ce(ce), .u(osc_if.unit));
  cssrs_src_switch #(.W(SW), .RESET_SEL(cssrs_pkg::SEL_RESET)) u_pll_sw (
    .pclk(pclk), .presetn(presetn), .ce(ce), .u(pll_if.unit));
  cssrs_src_switch #(.W(SW), .RESET_SEL(cssrs_pkg::SEL_RESET)) u_final_sw (
    .pclk(pclk), .presetn(presetn), .ce(ce), .u(final_if.unit));
  cssrs_src_switch #(.W(SW), .RESET_SEL(cssrs_pkg::SEL_RESET)) u_prepll_sw (
    .pclk(pclk), .presetn(presetn), .ce(ce), .u(prepll_if.unit));

  assign osc_direct_sel = osc_if.active;
  assign pll_src_sel = pll_if.active;
  assign main_final_sel = final_if.active;
  assign main_prepll_sel = prepll_if.active;

  // ----------------------------------------
  // Reset cause
  // ----------------------------------------
  cssrs_reset_cause u_rc (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .src_async(reset_src),
    .clear_we(rc_clear_we),
    .clear_bits(pwdata[cssrs_pkg::RC_W-1:0]),
    .flags(rc_flags),
    .new_event(rc_event)
  );

  // ----------------------------------------
  // System clock divider
  // ----------------------------------------
  always_comb
  begin
    next_main_clk_stopped = !(final_if.active == cssrs_pkg::FINAL_PREPLL ||
      final_if.active == cssrs_pkg::FINAL_PLL);
    next_div_cnt = div_cnt;
    next_sys_clk_en = 1'b0;
    if (ratio == 8'h00 || next_main_clk_stopped)
    begin
      next_div_cnt = 8'h00;
    end
    else if (div_cnt >= ratio - 8'h01)
    begin
      next_div_cnt = 8'h00;
      next_sys_clk_en = 1'b1;
    end
    else
    begin
      next_div_cnt = div_cnt + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt <= 8'h00;
      sys_clk_en <= 1'b0;
      main_clk_stopped <= 1'b0;
    end
    else if (ce)
    begin
      div_cnt <= next_div_cnt;
      sys_clk_en <= next_sys_clk_en;
      main_clk_stopped <= next_main_clk_stopped;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_ratio_zero;
    @(posedge pclk) disable iff (!presetn)
    (ratio == 8'h00) [*2] |-> !sys_clk_en;
  endproperty
  a_ratio_zero: assert property (p_ratio_zero)
    else $error("System clock enable active with ratio zero");

  property p_ratio_three;
    @(posedge pclk) disable iff (!presetn || !ce)
    (ce && sys_clk_en && ratio == 8'h03 && !main_clk_stopped) [*1] ##1
      (ce && ratio == 8'h03 && !main_clk_stopped) [*3]
      |-> !$past(sys_clk_en, 1) && !$past(sys_clk_en, 2) && sys_clk_en;
  endproperty
  a_ratio_three: assert property (p_ratio_three)
    else $error("Divide by three produced wrong enable spacing");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    ##1 (irq == |($past(next_irq_status) & $past(next_irq_mask)) || !$past(ce));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Interrupt output disagrees with status and mask");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    (ce && access && paddr == 32'h40048034) |=> (pready && pslverr && prdata == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped address not answered with an error");

  property p_zero_no_switch;
    @(posedge pclk) disable iff (!presetn)
    (ce && wr && paddr == cssrs_pkg::ADDR_PLL_UPD && !pwdata[0] && !strobe[1]
      && pll_src_sel == $past(pll_src_sel)) ##1 (!strobe[1] && !pll_if.done) [*6]
      |-> pll_src_sel == $past(pll_src_sel, 6);
  endproperty
  a_zero_no_switch: assert property (p_zero_no_switch)
    else $error("PLL source changed without a strobe rise");

  property p_final_zero;
    @(posedge pclk) disable iff (!presetn)
    (main_final_sel != $past(main_final_sel)) |-> final_if.done;
  endproperty
  a_final_zero: assert property (p_final_zero)
    else $error("Final main selection changed outside an update");

  property p_stopped;
    @(posedge pclk) disable iff (!presetn || !ce)
    (main_final_sel[1] && $past(main_final_sel[1])) |-> ##1 (main_clk_stopped || !ce);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("Main clock not stopped for selector codes two and three");

  property p_stop_gate;
    @(posedge pclk) disable iff (!presetn)
    main_clk_stopped |-> !sys_clk_en;
  endproperty
  a_stop_gate: assert property (p_stop_gate)
    else $error("System clock enable active while main clock stopped");

  property p_cause_reserved;
    @(posedge pclk) disable iff (!presetn)
    (ce && access && paddr == cssrs_pkg::ADDR_RST_CAUSE) |=> (prdata[31:5] == 27'h0);
  endproperty
  a_cause_reserved: assert property (p_cause_reserved)
    else $error("Reserved reset cause bits read nonzero");

  property p_pready_pulse;
    @(posedge pclk) disable iff (!presetn)
    (ce && pready) |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("Ready held longer than one cycle");

endmodule // cssrs_top

// ===== common/cssrs_pkg.sv
// Constants and types shared by the clock source select and reset status block
package cssrs_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [31:0] ADDR_OSC_FREQ_CTRL = 32'h40048028;
  localparam logic [31:0] ADDR_OSC_UPD = 32'h40048030;
  localparam logic [31:0] ADDR_RST_CAUSE = 32'h40048038;
  localparam logic [31:0] ADDR_PLL_SEL = 32'h40048040;
  localparam logic [31:0] ADDR_PLL_UPD = 32'h40048044;
  localparam logic [31:0] ADDR_FINAL_SEL = 32'h40048048;
  localparam logic [31:0] ADDR_FINAL_UPD = 32'h4004804c;
  localparam logic [31:0] ADDR_PREPLL_SEL = 32'h40048050;
  localparam logic [31:0] ADDR_PREPLL_UPD = 32'h40048054;
  localparam logic [31:0] ADDR_RATIO = 32'h40048058;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h400480f0;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h400480f4;
  // ----------------------------------------
  // Field positions and widths
  // ----------------------------------------
  localparam int OSC_DIRECT_BIT = 17;
  localparam int UPDATE_STROBE_BIT = 0;
  localparam int SEL_W = 2;
  localparam int RATIO_W = 8;
  localparam int RC_W = 5;
  localparam int RC_POR = 0;
  localparam int RC_PIN = 1;
  localparam int RC_WDT = 2;
  localparam int RC_BOD = 3;
  localparam int RC_SW = 4;
  localparam int IRQ_W = 5;
  localparam int IRQ_OSC = 0;
  localparam int IRQ_PLL = 1;
  localparam int IRQ_FINAL = 2;
  localparam int IRQ_PREPLL = 3;
  localparam int IRQ_RST = 4;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [1:0] SRC_OSC = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_WDOSC = 2'h2;
  localparam logic [1:0] SRC_OSC_HALF = 2'h3;
  localparam logic [1:0] FINAL_PREPLL = 2'h0;
  localparam logic [1:0] FINAL_PLL = 2'h1;
  localparam logic [7:0] RATIO_RESET = 8'h01;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 10;
  localparam int SWITCH_HOLD_NS = 20;
  localparam int SWITCH_HOLD_CYC = (SWITCH_HOLD_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic {CSSRS_IDLE, CSSRS_HOLD} cssrs_sw_state_e;
endpackage

// ===== common/cssrs_upd_if.sv
// Selection update handshake between register file and source switch
`timescale 1ns/1ps
interface cssrs_upd_if #(parameter int W = 2);
  logic [W-1:0] pending;
  logic strobe;
  logic [W-1:0] active;
  logic done;
  modport ctrl (output pending, output strobe, input active, input done);
  modport unit (input pending, input strobe, output active, output done);
endinterface

// ===== core/cssrs_src_switch.sv
// Strobe-triggered glitch-safe source switch
`timescale 1ns/1ps
module cssrs_src_switch #(
  parameter int W = 2,
  parameter logic [W-1:0] RESET_SEL = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Update handshake
  cssrs_upd_if.unit u
);
  localparam int HOLD = cssrs_pkg::SWITCH_HOLD_CYC;
  localparam logic [3:0] HOLD_LAST = 4'(HOLD - 1);

  cssrs_pkg::cssrs_sw_state_e state, next_state;
  logic strobe_q, next_strobe_q;
  logic [W-1:0] shadow, next_shadow;
  logic [W-1:0] active, next_active;
  logic done, next_done;
  logic [3:0] cnt, next_cnt;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_strobe_q = u.strobe;
    next_shadow = shadow;
    next_active = active;
    next_done = 1'b0;
    next_cnt = cnt;
    case (state)
      cssrs_pkg::CSSRS_IDLE:
      begin
        if (u.strobe && !strobe_q)
        begin
          next_shadow = u.pending;
          next_cnt = 4'h0;
          next_state = cssrs_pkg::CSSRS_HOLD;
        end
      end
      cssrs_pkg::CSSRS_HOLD:
      begin
        if (cnt == HOLD_LAST)
        begin
          next_active = shadow;
          next_done = 1'b1;
          next_state = cssrs_pkg::CSSRS_IDLE;
        end
        else
        begin
          next_cnt = cnt + 4'h1;
        end
      end
      default:
      begin
        next_state = cssrs_pkg::CSSRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= cssrs_pkg::CSSRS_IDLE;
      strobe_q <= 1'b0;
      shadow <= RESET_SEL;
      active <= RESET_SEL;
      done <= 1'b0;
      cnt <= 4'h0;
    end
    else if (ce)
    begin
      state <= next_state;
      strobe_q <= next_strobe_q;
      shadow <= next_shadow;
      active <= next_active;
      done <= next_done;
      cnt <= next_cnt;
    end
  end

  assign u.active = active;
  assign u.done = done;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_only_on_done;
    @(posedge pclk) disable iff (!presetn)
    (active != $past(active)) |-> done;
  endproperty
  a_only_on_done: assert property (p_only_on_done)
    else $error("Active source changed without a completed update");

  property p_rise_applies;
    @(posedge pclk) disable iff (!presetn || !ce)
    (ce && u.strobe && !strobe_q && state == cssrs_pkg::CSSRS_IDLE) ##1 ce [*2]
      |=> (done && active == $past(u.pending, 3));
  endproperty
  a_rise_applies: assert property (p_rise_applies)
    else $error("Strobe rise did not apply the pending source in time");

endmodule // cssrs_src_switch

// ===== core/cssrs_reset_cause.sv
// Reset cause flags with synchronised source inputs
`timescale 1ns/1ps
module cssrs_reset_cause (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Reset source levels, asynchronous, active high
  input wire logic [3:0] src_async,
  // Software clear
  input wire logic clear_we,
  input wire logic [cssrs_pkg::RC_W-1:0] clear_bits,
  // Status
  output logic [cssrs_pkg::RC_W-1:0] flags,
  output logic new_event
);
  logic [3:0] sync1, sync2, prev;
  logic por_seen, next_por_seen;
  logic [cssrs_pkg::RC_W-1:0] next_flags, set_bits;
  logic next_new_event;

  // ----------------------------------------
  // Flag update
  // ----------------------------------------
  always_comb
  begin
    set_bits = {sync2 & ~prev, ~por_seen};
    next_por_seen = 1'b1;
    next_flags = flags;
    if (clear_we)
    begin
      next_flags = next_flags & ~clear_bits;
    end
    next_flags = next_flags | set_bits;
    next_new_event = |set_bits;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      prev <= 4'h0;
      por_seen <= 1'b0;
      flags <= '0;
      new_event <= 1'b0;
    end
    else if (ce)
    begin
      sync1 <= src_async;
      sync2 <= sync1;
      prev <= sync2;
      por_seen <= next_por_seen;
      flags <= next_flags;
      new_event <= next_new_event;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (ce && (sync2[0] && !prev[0])) |=> flags[cssrs_pkg::RC_PIN];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Pin reset event not recorded");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    (ce && clear_we && clear_bits[cssrs_pkg::RC_BOD] && !(sync2[2] && !prev[2]))
      |=> !flags[cssrs_pkg::RC_BOD];
  endproperty
  a_clear: assert property (p_clear)
    else $error("Brown-out flag not cleared by a one");

  property p_zero_keeps;
    @(posedge pclk) disable iff (!presetn)
    (ce && flags[cssrs_pkg::RC_WDT] && !(clear_we && clear_bits[cssrs_pkg::RC_WDT]))
      |=> flags[cssrs_pkg::RC_WDT];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("Watchdog flag lost without a clear");

endmodule // cssrs_reset_cause

// ===== test/cssrs_top_tb.sv
// Self-checking testbench for the clock select and reset status block
`timescale 1ns/1ps
module cssrs_top_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk = 0;
  logic presetn = 0;
  logic ce = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] reset_src = '0;
  logic osc_direct_sel;
  logic [1:0] pll_src_sel;
  logic [1:0] main_prepll_sel;
  logic [1:0] main_final_sel;
  logic main_clk_stopped;
  logic sys_clk_en;
  logic irq;
  logic [31:0] rdat;
  logic err;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  always #5 pclk = ~pclk;
  cssrs_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_src(reset_src), .osc_direct_sel(osc_direct_sel),
    .pll_src_sel(pll_src_sel), .main_prepll_sel(main_prepll_sel),
    .main_final_sel(main_final_sel), .main_clk_stopped(main_clk_stopped),
    .sys_clk_en(sys_clk_en), .irq(irq));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a);
    apb(1'b0, a, '0);
  endtask
  task automatic reset_dut;
    presetn <= 0;
    wt(5);
    presetn <= 1;
    wt(8);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(cssrs_pkg::ADDR_RATIO);
    chk(rdat, 32'h00000001);
    rd(cssrs_pkg::ADDR_RST_CAUSE);
    chk(rdat, 32'h00000001);
    chk({pll_src_sel, main_prepll_sel, main_final_sel}, '0);
    $display("reset test done");
  endtask
  task automatic t_sel;
    for (int v = 1; v < 4; v++)
    begin
      wr(cssrs_pkg::ADDR_PLL_SEL, v);
      wr(cssrs_pkg::ADDR_PREPLL_SEL, v);
      wr(cssrs_pkg::ADDR_PLL_UPD, 0);
      wr(cssrs_pkg::ADDR_PREPLL_UPD, 0);
      chk({pll_src_sel, main_prepll_sel}, {2'(v - 1), 2'(v - 1)});
      wr(cssrs_pkg::ADDR_PLL_UPD, 1);
      wr(cssrs_pkg::ADDR_PREPLL_UPD, 1);
      wt(6);
      chk({pll_src_sel, main_prepll_sel}, {2'(v), 2'(v)});
    end
    wr(cssrs_pkg::ADDR_PLL_SEL, 32'hffffffff);
    rd(cssrs_pkg::ADDR_PLL_SEL);
    chk(rdat, 32'h00000003);
    $display("select test done");
  endtask
  task automatic t_final;
    wr(cssrs_pkg::ADDR_FINAL_SEL, 1);
    wr(cssrs_pkg::ADDR_FINAL_UPD, 1);
    wt(6);
    chk(main_final_sel, 2'h1);
    wr(cssrs_pkg::ADDR_FINAL_SEL, 2);
    wr(cssrs_pkg::ADDR_FINAL_UPD, 1);
    wt(6);
    chk(main_final_sel, 2'h1);
    wr(cssrs_pkg::ADDR_FINAL_UPD, 0);
    wr(cssrs_pkg::ADDR_FINAL_UPD, 1);
    wt(6);
    chk({main_final_sel, main_clk_stopped}, 3'b101);
    wt(1);
    chk(sys_clk_en, 1'b0);
    wr(cssrs_pkg::ADDR_OSC_FREQ_CTRL, 32'h00020000);
    chk(osc_direct_sel, 1'b0);
    wr(cssrs_pkg::ADDR_OSC_UPD, 0);
    wr(cssrs_pkg::ADDR_OSC_UPD, 1);
    wt(6);
    chk(osc_direct_sel, 1'b1);
    wr(cssrs_pkg::ADDR_OSC_FREQ_CTRL, 0);
    wr(cssrs_pkg::ADDR_OSC_UPD, 0);
    wr(cssrs_pkg::ADDR_OSC_UPD, 1);
    ce <= 0;
    wt(6);
    chk(osc_direct_sel, 1'b1);
    ce <= 1;
    wt(6);
    chk(osc_direct_sel, 1'b0);
    $display("final select test done");
  endtask
  int n_tab[3] = '{0, 3, 1};
  task automatic t_ratio;
    int n;
    wr(cssrs_pkg::ADDR_FINAL_SEL, 0);
    wr(cssrs_pkg::ADDR_FINAL_UPD, 0);
    wr(cssrs_pkg::ADDR_FINAL_UPD, 1);
    foreach (n_tab[i])
    begin
      wr(cssrs_pkg::ADDR_RATIO, n_tab[i]);
      wt(10);
      n = 0;
      repeat (30)
      begin
        @(posedge pclk);
        n += (sys_clk_en === 1'b1);
      end
      chk(n, n_tab[i] == 0 ? 0 : 30 / n_tab[i]);
    end
    $display("divider test done");
  endtask
  task automatic t_cause;
    wr(cssrs_pkg::ADDR_RST_CAUSE, 32'h0000001f);
    for (int i = 0; i < 4; i++)
    begin
      reset_src[i] <= 1;
      wt(3);
      reset_src[i] <= 0;
      wt(6);
      rd(cssrs_pkg::ADDR_RST_CAUSE);
      chk(rdat, 32'h2 << i);
      wr(cssrs_pkg::ADDR_RST_CAUSE, 32'hffffffe0 | ~(32'h2 << i));
      rd(cssrs_pkg::ADDR_RST_CAUSE);
      chk(rdat, 32'h2 << i);
      wr(cssrs_pkg::ADDR_RST_CAUSE, 32'h2 << i);
      rd(cssrs_pkg::ADDR_RST_CAUSE);
      chk(rdat, 32'h0);
    end
    reset_src[2] <= 1;
    wt(3);
    reset_src[2] <= 0;
    reset_src[0] <= 1;
    wt(6);
    reset_dut();
    reset_src[0] <= 0;
    rd(cssrs_pkg::ADDR_RST_CAUSE);
    chk(rdat, 32'h00000003);
    $display("reset cause test done");
  endtask
  task automatic t_irq;
    wr(cssrs_pkg::ADDR_IRQ_MASK, 0);
    wr(cssrs_pkg::ADDR_IRQ_STATUS, 32'h1f);
    wr(cssrs_pkg::ADDR_PLL_UPD, 0);
    wr(cssrs_pkg::ADDR_PLL_UPD, 1);
    wt(6);
    chk(irq, 1'b0);
    rd(cssrs_pkg::ADDR_IRQ_STATUS);
    chk(rdat, 32'h2);
    wr(cssrs_pkg::ADDR_IRQ_MASK, 32'h2);
    wt(2);
    chk(irq, 1'b1);
    wr(cssrs_pkg::ADDR_IRQ_STATUS, 32'h2);
    wt(2);
    chk(irq, 1'b0);
    rd(32'h40048034);
    chk({31'h0, err}, 32'h1);
    chk(rdat, 32'h0);
    $display("interrupt test done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    reset_dut();
    t_reset();
    t_sel();
    t_final();
    t_ratio();
    t_cause();
    t_irq();
    end_sim();
  end
endmodule // cssrs_top_tb
